// >>> core/rfid_dev.sv
// Device end: 12-byte data queue, transmit length, level flags, interrupt causes
// and start/stop framing of the parallel host port.
// Assumes air coder and decoder sit on the user-side ports; port clock from host.
//
// Operation
// - Twelve-byte circular queue at register 1F
// - Direct command 0F empties the queue
// - Status low nibble shows stored bytes minus one
// - Twelve-bit length plus broken bits decide EOF
// - Overflow bit set when loaded beyond capacity
// - Low bit when three bytes remain to send
// - High bit when nine bytes held receiving
// - Interrupt when queue falls to three or reaches nine
// - Host loads at most twelve, refills longer frames
// - Transmission starts on first queued byte
// - Strobe rise, clock high: start, address first
// - Strobe fall, clock high: simple stop
// - Rise and fall, clock low: continuous stop
// - Simple stop ends direct mode
// - Detected start of frame sets cause bit 6
// - Short receive interrupts only at end
// - Long receive interrupts at ninth byte, end
// - Receive faults set framing or CRC cause
// - Host resets queue, then burst from 1D
// - Length bytes then data in one burst
// - Transmit start sets cause bit 7
// - Long transmit also interrupts at level three
`timescale 1ns/1ps
`include "rfid_cfg.svh"
module rfid_dev
	import rfid_pkg::*;
#(
	parameter int unsigned BYTE_CYC = `TX_BYTE_NS / `CLK_NS
) (
	input wire logic CLK,
	input wire logic RST_N,
	rfid_link_if.dev LNK,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	output logic TX_EOF,
	input wire logic RX_SOF,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_END,
	input wire logic RX_FRAME_ERR,
	input wire logic RX_CRC_ERR,
	input wire logic DIRECT_ENTER,
	output logic DIRECT_MODE
);
	link_s lk_q, lk_d;
	dev_s q, d;
	logic word, hpush, hpop, tpop, rpush, push, pw, full, frst;
	logic rise, fall, lh, stop, clr, fire;
	logic [7:0] set, wbyte;
	logic [12:0] total;

	// Wrap a queue pointer after the last location
	function automatic logic [3:0] nxt(input logic [3:0] p);
		return (p == `FIFO_LAST) ? 4'h0 : 4'(p + 4'h1);
	endfunction

	// Read mux; queue reads zero when empty
	function automatic logic [7:0] rreg(input dev_s s);
		case (s.addr)
			`ADR_CAUSE: return s.cause;
			`ADR_FSTAT: return {1'b0, s.high, s.low, s.ovf, 4'(s.cnt - 4'h1)};
			`ADR_TXH: return s.txh;
			`ADR_TXL: return s.txl;
			`ADR_FIFO: return (s.cnt == 4'h0) ? 8'h00 : s.mem[s.rp];
			default: return 8'h00;
		endcase
	endfunction

	// Link domain: bus taken on each port clock rise, toggle marks a new word
	always_comb begin
		lk_d.hold = LNK.bus;
		lk_d.tog = !lk_q.tog;
	end

	// Port clock may be stopped in reset, so this domain resets asynchronously
	always_ff @(posedge LNK.lclk or negedge RST_N) begin
		if (!RST_N) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// Core next state
	always_comb begin
		d = q;
		d.tx_valid = 1'b0;
		d.tx_eof = 1'b0;
		d.lclk_s1 = LNK.lclk;
		d.lclk_s2 = q.lclk_s1;
		d.stb_s1 = LNK.strobe;
		d.stb_s2 = q.stb_s1;
		d.stb_p = q.stb_s2;
		d.tog_s1 = lk_q.tog;
		d.tog_s2 = q.tog_s1;
		d.tog_p = q.tog_s2;
		word = q.tog_s2 != q.tog_p;
		hpush = 1'b0;
		hpop = 1'b0;
		tpop = 1'b0;
		frst = 1'b0;
		fire = 1'b0;
		set = 8'h00;
		// Hold is stable here: it changes only one port clock after the toggle
		if (word && q.frame == FR_ADDR) begin
			if (lk_q.hold[`W_CMD]) begin
				frst = lk_q.hold[4:0] == `CMD_FIFO_RESET;
			end else begin
				d.addr = lk_q.hold[4:0];
				d.rd = lk_q.hold[`W_RD];
				d.cont = lk_q.hold[`W_CONT];
				d.frame = FR_DATA;
			end
		end else if (word && q.frame == FR_DATA) begin
			if (q.rd) begin
				hpop = q.addr == `ADR_FIFO && q.cnt != 4'h0;
				d.clr_pend = q.clr_pend || q.addr == `ADR_CAUSE;
			end else begin
				case (q.addr)
					`ADR_TXH: d.txh = lk_q.hold;
					`ADR_TXL: d.txl = lk_q.hold;
					`ADR_FIFO: hpush = 1'b1;
					default: ;
				endcase
			end
			// Burst walks 1D, 1E, then stays on the queue
			if (q.cont && q.addr != `ADR_FIFO) begin
				d.addr = 5'(q.addr + 5'h01);
			end
		end
		// Queue writes from host or receiver, one per cycle
		rpush = RX_VALID && q.rx_act;
		push = hpush || rpush;
		wbyte = hpush ? lk_q.hold : RX_DATA;
		full = q.cnt == `FIFO_DEPTH;
		if (push && full) begin
			d.ovf = 1'b1;
		end
		// Partial last byte counts as one more air byte
		total = 13'({q.txh, q.txl[7:4]}) + 13'(q.txl[3:0] != 4'h0);
		if (hpush && !q.tx_act && total != 13'h0000) begin
			d.tx_act = 1'b1;
			d.tx_rem = total;
			d.tx_big = total >= `TX_BIG;
			d.tx_tmr = 16'(BYTE_CYC);
			set[`B_TX] = 1'b1;
		end
		// Air byte pacing; an empty queue simply stalls the coder
		if (q.tx_act) begin
			if (q.tx_tmr != 16'h0000) begin
				d.tx_tmr = 16'(q.tx_tmr - 16'h0001);
			end else if (q.cnt != 4'h0 && !hpop) begin
				tpop = 1'b1;
				d.tx_data = q.mem[q.rp];
				d.tx_valid = 1'b1;
				d.tx_rem = 13'(q.tx_rem - 13'h0001);
				d.tx_tmr = 16'(BYTE_CYC);
				if (q.tx_rem == 13'h0001) begin
					d.tx_act = 1'b0;
					d.tx_eof = 1'b1;
					set[`B_TX] = 1'b1;
					fire = 1'b1;
				end
			end
		end
		// Circular storage update
		pw = push && !full;
		if (pw) begin
			d.mem[q.wp] = wbyte;
			d.wp = nxt(q.wp);
		end
		if (hpop || tpop) begin
			d.rp = nxt(q.rp);
		end
		d.cnt = 4'(q.cnt + {3'b000, pw} - {3'b000, hpop || tpop});
		// Level interrupts: refill point on long sends, drain point on receive
		if (q.tx_act && q.tx_big && q.cnt > `LVL_LOW && d.cnt <= `LVL_LOW) begin
			set[`B_FIFO] = 1'b1;
			fire = 1'b1;
		end
		if (q.rx_act && q.cnt < `LVL_HIGH && d.cnt >= `LVL_HIGH) begin
			set[`B_FIFO] = 1'b1;
			fire = 1'b1;
		end
		// Receive side events
		if (RX_SOF) begin
			d.rx_act = 1'b1;
			set[`B_RX] = 1'b1;
		end
		if (RX_END && q.rx_act) begin
			d.rx_act = 1'b0;
			set[`B_RX] = 1'b1;
			fire = 1'b1;
		end
		if (RX_FRAME_ERR || RX_CRC_ERR) begin
			d.rx_act = 1'b0;
			set[`B_FRM] = RX_FRAME_ERR;
			set[`B_CRC] = RX_CRC_ERR;
			fire = 1'b1;
		end
		if (frst) begin
			d.wp = 4'h0;
			d.rp = 4'h0;
			d.cnt = 4'h0;
			d.ovf = push && full; // Overflow in the same cycle still wins
		end
		d.high = d.rx_act && d.cnt >= `LVL_HIGH;
		d.low = d.tx_act && d.tx_rem == `TX_LOW_REM;
		// Framing from synchronised strobe and clock, same pipeline depth
		lh = q.lclk_s2;
		rise = q.stb_s2 && !q.stb_p;
		fall = !q.stb_s2 && q.stb_p;
		stop = 1'b0;
		if (rise && lh) begin
			d.frame = FR_ADDR;
			d.arm = 1'b0;
		end
		if (fall && lh) begin
			stop = 1'b1;
			d.direct = 1'b0;
		end
		if (rise && !lh) begin
			d.arm = 1'b1;
		end
		if (fall && !lh && q.arm) begin
			stop = 1'b1;
		end
		// Cause is cleared by the stop after it was read; new events win
		clr = stop && d.clr_pend;
		if (stop) begin
			d.frame = FR_IDLE;
			d.arm = 1'b0;
			d.clr_pend = 1'b0;
		end
		d.cause = (q.cause & ~{8{clr}}) | set;
		d.irq = (q.irq && !clr) || fire;
		if (DIRECT_ENTER) begin
			d.direct = 1'b1;
		end
		d.doe = d.frame == FR_DATA && d.rd;
		d.dout = rreg(q);
	end

	// Core state register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign LNK.d_o = q.dout;
	assign LNK.d_oe = q.doe;
	assign LNK.irq = q.irq;
	assign TX_DATA = q.tx_data;
	assign TX_VALID = q.tx_valid;
	assign TX_EOF = q.tx_eof;
	assign DIRECT_MODE = q.direct;
endmodule

// >>> core/rfid_cfg.svh
// Constants shared by both ends of the parallel host link and the FIFO logic.
// Assumes the including file is compiled after nothing else defines these names.
`ifndef RFID_CFG_SVH
`define RFID_CFG_SVH

// Register map (5-bit register addresses)
`define ADR_CAUSE 5'h0C
`define ADR_FSTAT 5'h1C
`define ADR_TXH 5'h1D
`define ADR_TXL 5'h1E
`define ADR_FIFO 5'h1F

// Address word layout and direct command codes
`define W_CMD 7
`define W_RD 6
`define W_CONT 5
`define CMD_FIFO_RESET 5'h0F

// Interrupt cause bits
`define B_TX 7
`define B_RX 6
`define B_FIFO 5
`define B_CRC 4
`define B_FRM 2

// FIFO status bits and levels
`define B_OVF 4
`define B_LOW 5
`define B_HIGH 6
`define FIFO_DEPTH 4'hC
`define FIFO_LAST 4'hB
`define LVL_LOW 4'h3
`define LVL_HIGH 4'h9
`define TX_BIG 13'h0005
`define TX_LOW_REM 13'h0003

// Timing: one air byte, the core clock period and the host port clock half period
`define TX_BYTE_NS 75520
`define CLK_NS 40
`define HOST_HALF 8

`endif

// >>> core/rfid_pkg.sv
// Types shared by the device end and the host end of the parallel link.
// Assumes rfid_cfg.svh is on the include path.
package rfid_pkg;
	`include "rfid_cfg.svh"

	typedef enum logic [1:0] {FR_IDLE, FR_ADDR, FR_DATA} frame_e;
	typedef enum logic [1:0] {H_IDLE, H_START, H_WORD, H_STOP} hstate_e;

	// Link-domain capture state of the device
	typedef struct packed {
		logic [7:0] hold;
		logic tog;
	} link_s;

	// Core-domain state of the device
	typedef struct packed {
		logic lclk_s1, lclk_s2, stb_s1, stb_s2, stb_p, tog_s1, tog_s2, tog_p;
		frame_e frame;
		logic arm, rd, cont, clr_pend;
		logic [4:0] addr;
		logic [11:0][7:0] mem;
		logic [3:0] wp, rp, cnt;
		logic ovf, low, high;
		logic [7:0] cause, txh, txl;
		logic tx_act, tx_big, rx_act;
		logic [12:0] tx_rem;
		logic [15:0] tx_tmr;
		logic [7:0] dout, tx_data;
		logic doe, irq, tx_valid, tx_eof, direct;
	} dev_s;

	// State of the host end
	typedef struct packed {
		hstate_e st;
		logic [5:0] ph;
		logic [3:0] idx, len;
		logic [7:0] word, h_o, rd_data, bus_s1, bus_s2;
		logic cstop, rdc, lclk, strobe, h_oe, irq_s1, irq_s2;
		logic cmd_rdy, wr_rdy, rd_valid;
	} host_s;
endpackage

// >>> core/rfid_link_if.sv
// Parallel host link: port clock, strobe, shared 8-bit bus and interrupt line.
// Bus level is resolved here from the two enables; undriven floats to all ones.
`timescale 1ns/1ps
interface rfid_link_if;
	logic lclk;
	logic strobe;
	logic irq;
	logic [7:0] h_o;
	logic [7:0] d_o;
	logic [7:0] bus;
	logic h_oe;
	logic d_oe;

	// Device drive wins so a late host release never shows as a conflict
	assign bus = d_oe ? d_o : (h_oe ? h_o : 8'hFF);

	modport host(output lclk, strobe, h_o, h_oe, input bus, irq);
	modport dev(input lclk, strobe, bus, output d_o, d_oe, irq);
endinterface

// >>> core/rfid_host.sv
// Host end: makes the port clock by division, frames start/stop, moves words.
// Assumes the device answers a read within one port clock period.
`timescale 1ns/1ps
`include "rfid_cfg.svh"
module rfid_host
	import rfid_pkg::*;
#(
	parameter int unsigned HALF = `HOST_HALF
) (
	input wire logic CLK,
	input wire logic RST_N,
	rfid_link_if.host LNK,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [7:0] CMD_WORD,
	input wire logic [3:0] CMD_LEN,
	input wire logic CMD_CONT_STOP,
	input wire logic WR_VALID,
	output logic WR_READY,
	input wire logic [7:0] WR_DATA,
	output logic RD_VALID,
	output logic [7:0] RD_DATA,
	output logic IRQ
);
	localparam logic [5:0] PH_MID = 6'(HALF / 2);
	localparam logic [5:0] PH_FALL = 6'(HALF);
	localparam logic [5:0] PH_LAST = 6'(2 * HALF - 1);

	host_s q, d;
	logic stall;

	// Next state; port clock is high in the first half of each period
	always_comb begin
		d = q;
		d.rd_valid = 1'b0;
		d.irq_s1 = LNK.irq;
		d.irq_s2 = q.irq_s1;
		d.bus_s1 = LNK.bus;
		d.bus_s2 = q.bus_s1;
		// Clock held low while waiting for write data: real back-pressure
		stall = q.wr_rdy && !WR_VALID;
		if (!stall) begin
			d.ph = (q.ph == PH_LAST) ? 6'h00 : 6'(q.ph + 6'h01);
		end
		d.lclk = d.ph < PH_FALL;
		// Release one cycle after the rise; the device captured on it
		if (q.ph == 6'h00) begin
			d.h_oe = 1'b0;
		end
		case (q.st)
			H_IDLE: begin
				d.cmd_rdy = 1'b1;
				if (q.cmd_rdy && CMD_VALID) begin
					d.cmd_rdy = 1'b0;
					d.word = CMD_WORD;
					d.len = CMD_LEN;
					d.cstop = CMD_CONT_STOP;
					d.rdc = CMD_WORD[`W_RD] && !CMD_WORD[`W_CMD];
					d.idx = 4'h0;
					d.st = H_START;
				end
			end
			H_START: begin
				if (q.ph == PH_MID) begin
					d.strobe = 1'b1;
					d.st = H_WORD;
				end
			end
			H_WORD: begin
				if (q.ph == PH_FALL - 6'h01) begin
					if (q.idx == 4'h0) begin
						d.h_o = q.word;
						d.h_oe = 1'b1;
					end else if (!q.rdc) begin
						d.wr_rdy = 1'b1;
					end
				end
				if (q.wr_rdy && WR_VALID) begin
					d.wr_rdy = 1'b0;
					d.h_o = WR_DATA;
					d.h_oe = 1'b1;
				end
				if (q.ph == PH_LAST) begin
					if (q.idx != 4'h0 && q.rdc) begin
						d.rd_valid = 1'b1;
						d.rd_data = q.bus_s2;
					end
					d.idx = 4'(q.idx + 4'h1);
					// Word count is the caller's; at most 12 FIFO bytes per load
					if (q.idx == q.len) begin
						d.st = H_STOP;
					end
				end
			end
			H_STOP: begin
				if (!q.cstop && q.ph == PH_MID) begin
					d.strobe = 1'b0;
					d.st = H_IDLE;
				end
				// Drop, then pulse, all while the clock is low
				if (q.cstop && q.ph == PH_FALL + 6'h01) begin
					d.strobe = 1'b0;
				end
				if (q.cstop && q.ph == PH_FALL + 6'h03) begin
					d.strobe = 1'b1;
				end
				if (q.cstop && q.ph == PH_FALL + 6'h06) begin
					d.strobe = 1'b0;
					d.st = H_IDLE;
				end
			end
			default: d.st = H_IDLE;
		endcase
	end

	// Single state register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			q <= '0;
			// Start at the end of a low half so the first high half is full length
			q.ph <= PH_LAST;
		end else begin
			q <= d;
		end
	end

	assign LNK.lclk = q.lclk;
	assign LNK.strobe = q.strobe;
	assign LNK.h_o = q.h_o;
	assign LNK.h_oe = q.h_oe;
	assign CMD_READY = q.cmd_rdy;
	assign WR_READY = q.wr_rdy;
	assign RD_VALID = q.rd_valid;
	assign RD_DATA = q.rd_data;
	assign IRQ = q.irq_s2;
endmodule

// >>> sim/rfid_link_assertions.sv
// Checker for the parallel host link joining the host end and the device end.
// Assumes both ends share CLK and the host port clock half period is 8 cycles.
`timescale 1ns/1ps
module rfid_link_assertions (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic lclk,
	input wire logic strobe,
	input wire logic irq,
	input wire logic [7:0] h_o,
	input wire logic h_oe,
	input wire logic d_oe
);
	// One clock domain, so one default clocking and reset
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_clk_high_half: assert property ($rose(lclk) |-> lclk [*8] ##1 !lclk)
		else $error("port clock high phase wrong");
	a_clk_low_half: assert property ($fell(lclk) |-> !lclk [*8] ##1 lclk)
		else $error("port clock low phase wrong");
	a_strobe_off_edge: assert property ($changed(lclk) |-> $stable(strobe))
		else $error("strobe moved on a port clock edge");
	a_data_held_rise: assert property ($rose(lclk) && h_oe |-> $stable(h_o))
		else $error("host data moved at capture edge");
	a_no_drive_clash: assert property (!(h_oe && d_oe))
		else $error("both ends drive the bus");
	a_addr_after_start: assert property ($rose(strobe) && lclk |-> ##[1:8] h_oe)
		else $error("no address word after start");
	a_dev_release_stop: assert property ($fell(strobe) && lclk |-> ##[1:8] !d_oe)
		else $error("device still drives after stop");
	a_irq_clear_stop: assert property ($fell(irq) |-> !strobe)
		else $error("interrupt dropped inside a frame");
	a_dev_drive_frame: assert property ($rose(d_oe) |-> strobe)
		else $error("device drove outside a frame");
endmodule

// >>> sim/tb_rfid_fifo_host_transfer.sv
// Bench joining the host end and the device end over the parallel link.
// Assumes one 25 MHz clock for both ends; air byte time cut to 41 cycles.
`timescale 1ns/1ps
module tb_rfid_fifo_host_transfer;
	import rfid_pkg::*;
	logic clk = 0, rst_n = 0, cmd_valid = 0, cmd_cont = 0, wr_valid = 0;
	logic [7:0] cmd_word = 0, wr_data = 0, rx_data = 0, rd_data, tx_data;
	logic [3:0] cmd_len = 0;
	logic [5:0] ev = 0;
	logic cmd_ready, wr_ready, rd_valid, irq, tx_valid, tx_eof, dmode;
	logic [7:0] wb [16], rb [16];
	logic [7:0] txq [$];
	int mismatches = 0, tests_run = 0, cyc = 0, eofs = 0, irqs = 0;
	rfid_link_if lnk();
	rfid_host i_rfid_host (.CLK(clk), .RST_N(rst_n), .LNK(lnk), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_WORD(cmd_word), .CMD_LEN(cmd_len), .CMD_CONT_STOP(cmd_cont),
		.WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid),
		.RD_DATA(rd_data), .IRQ(irq));
	rfid_dev #(.BYTE_CYC(40)) i_rfid_dev (.CLK(clk), .RST_N(rst_n), .LNK(lnk), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_EOF(tx_eof), .RX_SOF(ev[0]), .RX_VALID(ev[1]), .RX_DATA(rx_data),
		.RX_END(ev[2]), .RX_FRAME_ERR(ev[3]), .RX_CRC_ERR(ev[4]), .DIRECT_ENTER(ev[5]),
		.DIRECT_MODE(dmode));
	rfid_link_assertions i_rfid_link_assertions (.CLK(clk), .RST_N(rst_n), .lclk(lnk.lclk),
		.strobe(lnk.strobe), .irq(lnk.irq), .h_o(lnk.h_o), .h_oe(lnk.h_oe), .d_oe(lnk.d_oe));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Clock, cycle ceiling, air byte capture and interrupt edge count
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tx_valid === 1'b1) txq.push_back(tx_data);
		if (tx_eof === 1'b1) begin
			eofs <= eofs + 1;
			check("eof with byte", 8'(tx_valid), 8'h01);
		end
		if ($rose(lnk.irq)) irqs <= irqs + 1;
		// Ceiling well above the longest sequence; a hang still reaches the verdict
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end

	// One framed transfer; words go out of wb or come back into rb
	task automatic xfer(input logic [7:0] w, input int n, input logic cs = 0);
		int i;
		@(posedge clk);
		while (cmd_ready !== 1'b1) @(posedge clk);
		cmd_valid <= 1;
		cmd_word <= w;
		cmd_len <= 4'(n);
		cmd_cont <= cs;
		@(posedge clk);
		cmd_valid <= 0;
		for (i = 0; i < n; i++) begin
			if (w[6]) begin
				do @(negedge clk); while (rd_valid !== 1'b1);
				rb[i] = rd_data;
			end else begin
				wr_valid <= 1;
				wr_data <= wb[i];
				do @(posedge clk); while (wr_ready !== 1'b1);
			end
		end
		if (!w[6]) wr_valid <= 0;
		repeat (2) @(posedge clk);
		while (cmd_ready !== 1'b1) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask

	// Pulse one air-side event; index 1 carries a received byte
	task automatic pulse(input int k, input logic [7:0] d = 0);
		@(posedge clk);
		ev[k] <= 1;
		rx_data <= d;
		@(posedge clk);
		ev[k] <= 0;
		repeat (2) @(posedge clk);
	endtask

	task automatic wait_irq();
		int k;
		for (k = 0; k < 800 && irq !== 1'b1; k++) @(posedge clk);
		check("irq raised", 8'(irq), 8'h01);
	endtask

	// Registers straight after reset, unmapped place included
	task automatic t_idle();
		xfer(8'h5C, 1);
		check("status empty", rb[0], 8'h0F);
		xfer(8'h4C, 1);
		check("cause idle", rb[0], 8'h00);
		xfer(8'h45, 1);
		check("unmapped", rb[0], 8'h00);
	endtask

	// Burst from length bytes into the queue; long frames also warn at level three
	task automatic t_tx(input int n);
		int i;
		xfer(8'h8F, 0);
		txq.delete();
		eofs = 0;
		irqs = 0;
		wb[0] = 0;
		wb[1] = 8'(n << 4);
		for (i = 0; i < n; i++) wb[i + 2] = 8'hA0 + 8'(i);
		xfer(8'h3D, n + 2);
		wait_irq();
		if (n >= 5) begin
			check("early eof", 8'(eofs), 8'h00);
			xfer(8'h4C, 1);
			check("cause level", rb[0], 8'hA0);
			wait_irq();
		end
		check("eof count", 8'(eofs), 8'h01);
		check("irq edges", 8'(irqs), n >= 5 ? 8'h02 : 8'h01);
		check("tx count", 8'(txq.size()), 8'(n));
		for (i = 0; i < txq.size(); i++) check("tx byte", txq[i], wb[i + 2]);
		xfer(8'h4C, 1);
		check("cause done", rb[0], 8'h80);
		check("irq cleared", 8'(irq), 8'h00);
	endtask

	// Three bytes plus broken bits make four air bytes; a starved coder waits
	task automatic t_low();
		int i;
		xfer(8'h8F, 0);
		txq.delete();
		eofs = 0;
		irqs = 0;
		wb[0] = 0;
		wb[1] = 8'h34;
		for (i = 0; i < 4; i++) wb[i + 2] = 8'h50 + 8'(i);
		xfer(8'h3D, 3);
		repeat (40) @(posedge clk);
		xfer(8'h5C, 1);
		check("status low", rb[0], 8'h2F);
		for (i = 0; i < 3; i++) wb[i] = wb[i + 3];
		xfer(8'h1F, 3);
		wait_irq();
		check("short irq edges", 8'(irqs), 8'h01);
		check("broken eof", 8'(eofs), 8'h01);
		check("broken count", 8'(txq.size()), 8'h04);
		for (i = 0; i < txq.size(); i++) check("tx refill", txq[i], 8'h50 + 8'(i));
		xfer(8'h4C, 1);
		check("cause short", rb[0], 8'h80);
	endtask

	// Thirteen loads with no length: last one refused
	task automatic t_ovf();
		int i;
		xfer(8'h8F, 0);
		wb[0] = 0;
		wb[1] = 0;
		for (i = 2; i < 15; i++) wb[i] = 8'h10 + 8'(i);
		xfer(8'h3D, 15);
		xfer(8'h5C, 1);
		check("status full", rb[0], 8'h1B);
		xfer(8'h7F, 6);
		for (i = 0; i < 6; i++) check("queue order", rb[i], wb[i + 2]);
		xfer(8'h8F, 0);
		xfer(8'h5C, 1);
		check("status cleared", rb[0] & 8'h0F, 8'h0F);
	endtask

	// Nine received bytes warn before the end, then again at the end
	task automatic t_rx_long();
		int i;
		irqs = 0;
		pulse(0);
		for (i = 0; i < 9; i++) begin
			check("rx early irq", 8'(irqs), 8'h00);
			pulse(1, 8'hC0 + 8'(i));
		end
		wait_irq();
		xfer(8'h5C, 1);
		check("status high", rb[0], 8'h48);
		xfer(8'h4C, 1);
		check("cause high", rb[0], 8'h60);
		pulse(2);
		wait_irq();
		xfer(8'h7F, 9);
		for (i = 0; i < 9; i++) check("rx data", rb[i], 8'hC0 + 8'(i));
		xfer(8'h4C, 1);
		check("cause end", rb[0], 8'h40);
	endtask

	// Short frames ended by end, framing fault and check fault
	task automatic t_rx_short();
		int k;
		logic [7:0] cause [3] = '{8'h40, 8'h44, 8'h50};
		for (k = 0; k < 3; k++) begin
			irqs = 0;
			pulse(0);
			pulse(1, 8'h11);
			pulse(1, 8'h22);
			check("rx short irq", 8'(irqs), 8'h00);
			pulse(k + 2);
			wait_irq();
			xfer(8'h4C, 1);
			check("rx cause", rb[0], cause[k]);
			xfer(8'h8F, 0);
		end
	endtask

	// Continuous stop keeps direct mode, simple stop ends it
	task automatic t_direct();
		pulse(5);
		check("direct on", 8'(dmode), 8'h01);
		xfer(8'h5C, 1, 1);
		check("after cont stop", 8'(dmode), 8'h01);
		xfer(8'h5C, 1, 0);
		check("status after cont", rb[0], 8'h0F);
		check("after simple stop", 8'(dmode), 8'h00);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		t_idle();
		t_tx(3);
		t_tx(6);
		t_low();
		t_ovf();
		t_rx_long();
		t_rx_short();
		t_direct();
		test_done();
	end
endmodule
